// ### verilog/overdischarge_sleep_control.sv
/*
  Over-discharge protection and sleep control for a four-cell protection device.
  Assumes cell voltages as 8-bit codes, supply comparator level and host writes
  already decoded into strobes; all inputs synchronous to ref_clk_in.
*/
// Summary of operation
// - Cell under threshold past delay: discharge off
// - Protection also turns charge off, enters sleep unless supply above return threshold
// - Two-bit field selects under-voltage threshold
// - Wake, charge on, release time, discharge on
// - Detect and release delays from one capacitor
// - Host sleep bit also enters sleep unless supply above return threshold
// - Asleep: both FETs off, regulator off
// - Asleep: FET control bits ignored
// - Asleep: host transfers have no effect
// - Supply at return threshold wakes device
// - Wake check: cell below charge-enable locks FETs
// - Two-bit field selects charge-enable voltage
// - Check-disable bit acts as zero threshold
// - No sleep while supply above return threshold
// - Charge FET off until host writes one
// - Discharge FET off until host writes one
// - Wake reset delay; FET writes then ignored
`timescale 1ns/10ps
`include "odp_map.svh"
module overdischarge_sleep_control #(
  parameter logic [39:0] DETECT_CYC  = 40'(`ODP_DETECT_CYC),
  parameter logic [39:0] RELEASE_CYC = 40'(`ODP_RELEASE_CYC),
  parameter logic [39:0] WAKE_CYC    = 40'(`ODP_WAKE_CYC),
  parameter logic [31:0] UV_TABLE    = 32'h40383028,
  parameter logic [31:0] UVR_TABLE   = 32'h48403830,
  parameter logic [31:0] CE_TABLE    = 32'h20181008
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [31:0] cell_volt_in,
  input  wire logic        supply_above_return_in,
  input  wire logic        config_write_cmd_in,
  input  wire logic [7:0]  config_data_in,
  input  wire logic        control_write_cmd_in,
  input  wire logic [7:0]  control_data_in,
  output logic             discharge_fet_drive_out,
  output logic             charge_fet_drive_out,
  output logic             regulator_output_out,
  output logic             spi_enable_out,
  output logic             sleeping_out,
  output logic             protect_active_out,
  output logic             charge_locked_out,
  output logic [7:0]       config_out
);
  odp_pkg::mode_e mode_r;
  odp_pkg::mode_e mode_nxt;
  logic [7:0]     config_r;
  logic           dfet_on_r;
  logic           cfet_on_r;
  logic           protect_r;
  logic           any_under;
  logic           all_above_n;
  logic           any_below_ce;
  logic           ce_check_on;
  logic           host_ok;
  logic           sleep_req;
  logic           go_sleep;
  logic           tmr_start;
  logic [1:0]     tmr_sel;
  logic           awake;
  logic           cfet_window;
  logic           dfet_window;
  logic           cfet_wr;
  logic           dfet_wr;
  logic           protect_trip;
  logic           release_done;
  odp_pkg::sel_t  uv_sel;
  odp_pkg::sel_t  ce_sel;

  // Mode decodes shared by write gating and output registers
  function automatic logic is_awake(input odp_pkg::mode_e m);
    is_awake = (m != odp_pkg::ST_SLEEP);
  endfunction

  function automatic logic charge_allowed(input odp_pkg::mode_e m);
    charge_allowed = (m == odp_pkg::ST_NORMAL) || (m == odp_pkg::ST_RECOVER);
  endfunction

  // Drive pins are active low: high keeps the FET off
  function automatic logic drive_level(input logic on, input logic window);
    drive_level = !(on && window);
  endfunction

  odp_timer_if tif ();

  odp_delay_timer #(
    .DETECT_CYC  (DETECT_CYC),
    .RELEASE_CYC (RELEASE_CYC),
    .WAKE_CYC    (WAKE_CYC)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .tmr        (tif.timer)
  );

  odp_cell_compare u_uv (
    .cells_in      (cell_volt_in),
    .thresh_tbl_in (UV_TABLE),
    .sel_in        (uv_sel),
    .above_in      (1'b0),
    .any_out       (any_under)
  );

  // Any cell not strictly above release threshold
  odp_cell_compare u_uvr (
    .cells_in      (cell_volt_in),
    .thresh_tbl_in (UVR_TABLE),
    .sel_in        (uv_sel),
    .above_in      (1'b1),
    .any_out       (all_above_n)
  );

  odp_cell_compare u_ce (
    .cells_in      (cell_volt_in),
    .thresh_tbl_in (CE_TABLE),
    .sel_in        (ce_sel),
    .above_in      (1'b0),
    .any_out       (any_below_ce)
  );

  // Disabled check behaves as a zero threshold
  assign ce_check_on = !config_r[`ODP_CFG_CHK_DIS];

  // Host writes only take effect when awake
  assign host_ok = awake;
  assign sleep_req = control_write_cmd_in && host_ok &&
                     control_data_in[`ODP_CTL_SLEEP];
  // Supply above return threshold blocks every entry to sleep
  assign go_sleep = !supply_above_return_in;

  assign uv_sel      = {config_r[`ODP_CFG_UV_HI], config_r[`ODP_CFG_UV_LO]};
  assign ce_sel      = {config_r[`ODP_CFG_CE_HI], config_r[`ODP_CFG_CE_LO]};
  assign awake       = is_awake(mode_r);
  assign cfet_window = charge_allowed(mode_r);
  assign dfet_window = (mode_r == odp_pkg::ST_NORMAL);
  assign cfet_wr     = control_write_cmd_in && cfet_window;
  assign dfet_wr     = control_write_cmd_in && dfet_window;
  // Timeout trips protection even when sleep is refused
  assign protect_trip = (mode_r == odp_pkg::ST_NORMAL) && tif.done;
  assign release_done = (mode_r == odp_pkg::ST_RECOVER) && (mode_nxt == odp_pkg::ST_NORMAL);

  always_comb begin
    tmr_start = 1'b0;
    tmr_sel   = 2'h0;
    case (mode_r)
      odp_pkg::ST_NORMAL: begin
        tmr_start = any_under;
        tmr_sel   = 2'h0;
      end
      odp_pkg::ST_WAKE: begin
        tmr_start = 1'b1;
        tmr_sel   = 2'h2;
      end
      odp_pkg::ST_RECOVER: begin
        // Release timer only runs once charge FET is on
        tmr_start = cfet_on_r && !all_above_n;
        tmr_sel   = 2'h1;
      end
      default: begin
        tmr_start = 1'b0;
        tmr_sel   = 2'h0;
      end
    endcase
  end

  assign tif.start = tmr_start;
  assign tif.sel   = tmr_sel;
  assign tif.clear = (mode_r != mode_nxt);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      odp_pkg::ST_NORMAL: begin
        if ((tif.done || sleep_req) && go_sleep) begin
          mode_nxt = odp_pkg::ST_SLEEP;
        end else if (tif.done) begin
          // Sleep refused: protect without it
          mode_nxt = odp_pkg::ST_RECOVER;
        end
      end
      odp_pkg::ST_SLEEP: begin
        if (supply_above_return_in) begin
          mode_nxt = odp_pkg::ST_WAKE;
        end
      end
      odp_pkg::ST_WAKE: begin
        if (tif.done) begin
          if (ce_check_on && any_below_ce) begin
            mode_nxt = odp_pkg::ST_LOCKED;
          end else if (protect_r) begin
            mode_nxt = odp_pkg::ST_RECOVER;
          end else begin
            mode_nxt = odp_pkg::ST_NORMAL;
          end
        end
      end
      odp_pkg::ST_LOCKED: begin
        if (sleep_req && go_sleep) begin
          mode_nxt = odp_pkg::ST_SLEEP;
        end else if (!ce_check_on || !any_below_ce) begin
          mode_nxt = protect_r ? odp_pkg::ST_RECOVER : odp_pkg::ST_NORMAL;
        end
      end
      odp_pkg::ST_RECOVER: begin
        if (sleep_req && go_sleep) begin
          mode_nxt = odp_pkg::ST_SLEEP;
        end else if (tif.done) begin
          mode_nxt = odp_pkg::ST_NORMAL;
        end
      end
      default: mode_nxt = odp_pkg::ST_SLEEP;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      // Reset behaves as a wake: full delay before FET writes
      mode_r <= odp_pkg::ST_WAKE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Latched at trip, cleared once release completes
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      protect_r <= 1'b0;
    end else if (protect_trip) begin
      protect_r <= 1'b1;
    end else if (release_done) begin
      protect_r <= 1'b0;
    end
  end

  // Configuration persists through sleep, as in nonvolatile storage
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      config_r <= `ODP_CFG_RESET;
    end else if (config_write_cmd_in && host_ok) begin
      config_r <= config_data_in;
    end
  end

  // FET enables cleared on sleep entry so wake starts with both off
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cfet_on_r <= 1'b0;
    end else if (mode_nxt == odp_pkg::ST_SLEEP || protect_trip) begin
      cfet_on_r <= 1'b0;
    end else if (cfet_wr) begin
      cfet_on_r <= control_data_in[`ODP_CTL_CFET];
    end
  end

  // Discharge stays off until release has completed
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      dfet_on_r <= 1'b0;
    end else if (mode_nxt == odp_pkg::ST_SLEEP || protect_trip || !dfet_window) begin
      dfet_on_r <= 1'b0;
    end else if (dfet_wr) begin
      dfet_on_r <= control_data_in[`ODP_CTL_DFET];
    end
  end

  // Discharge only ever on in normal mode
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      discharge_fet_drive_out <= 1'b1;
    end else begin
      discharge_fet_drive_out <= drive_level(dfet_on_r, dfet_window);
    end
  end

  // Charge may also be on while recovering
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      charge_fet_drive_out <= 1'b1;
    end else begin
      charge_fet_drive_out <= drive_level(cfet_on_r, cfet_window);
    end
  end

  // Regulator dropped only in sleep
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      regulator_output_out <= 1'b1;
    end else begin
      regulator_output_out <= awake;
    end
  end

  // Port answers only while awake
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      spi_enable_out <= 1'b1;
    end else begin
      spi_enable_out <= awake;
    end
  end

  // Sleep flag for the host side
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sleeping_out <= 1'b0;
    end else begin
      sleeping_out <= !awake;
    end
  end

  // Protection latch made visible
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      protect_active_out <= 1'b0;
    end else begin
      protect_active_out <= protect_r;
    end
  end

  // Wake check refused the FETs
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      charge_locked_out <= 1'b0;
    end else begin
      charge_locked_out <= (mode_r == odp_pkg::ST_LOCKED);
    end
  end

  // Read-back of stored configuration
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      config_out <= `ODP_CFG_RESET;
    end else begin
      config_out <= config_r;
    end
  end
endmodule

// ### include/odp_map.svh
/*
  Constants for the over-discharge and sleep control block.
  Assumes inclusion by bare name from any design or bench file.
*/
`ifndef ODP_MAP_SVH
`define ODP_MAP_SVH

// Clock period in picoseconds (200 MHz)
`define ODP_CLK_PS             64'd5000
// Detection delay with reference capacitor, in ms
`define ODP_DETECT_DELAY_MS    64'd1000
// Release time with reference capacitor, in us
`define ODP_RELEASE_TIME_US    64'd7000
// Extra internal reset time after wake, in ms
`define ODP_WAKE_EXTRA_MS      64'd200
// Cycle counts derived from the times above
`define ODP_DETECT_CYC   ((`ODP_DETECT_DELAY_MS * 64'd1000000000) / `ODP_CLK_PS)
`define ODP_RELEASE_CYC  ((`ODP_RELEASE_TIME_US * 64'd1000000) / `ODP_CLK_PS)
`define ODP_WAKE_CYC (((`ODP_DETECT_DELAY_MS + `ODP_WAKE_EXTRA_MS) * 64'd1000000000) / `ODP_CLK_PS)

// Configuration field positions
`define ODP_CFG_UV_LO          0
`define ODP_CFG_UV_HI          1
`define ODP_CFG_CE_LO          2
`define ODP_CFG_CE_HI          3
`define ODP_CFG_CHK_DIS        4
// Control field positions
`define ODP_CTL_DFET           0
`define ODP_CTL_CFET           1
`define ODP_CTL_SLEEP          2

// Reset values
`define ODP_CFG_RESET          8'h00
`define ODP_CTL_RESET          8'h00

`endif

// ### include/odp_pkg.sv
/*
  Types for the over-discharge and sleep control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package odp_pkg;
  typedef enum logic [4:0] {
    ST_NORMAL  = 5'b00001,
    ST_SLEEP   = 5'b00010,
    ST_WAKE    = 5'b00100,
    ST_LOCKED  = 5'b01000,
    ST_RECOVER = 5'b10000
  } mode_e;
  typedef logic [1:0] sel_t;
endpackage

// ### include/odp_timer_if.sv
/*
  Carrier between the controller and its delay timer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface odp_timer_if;
  logic        start;
  logic        clear;
  logic [1:0]  sel;
  logic        done;
  modport ctrl  (output start, output clear, output sel, input done);
  modport timer (input start, input clear, input sel, output done);
endinterface

// ### verilog/odp_delay_timer.sv
/*
  Delay timer standing in for the capacitor-set detection, release and wake delays.
  Assumes the controller holds start high for as long as the condition lasts.
*/
`timescale 1ns/10ps
`include "odp_map.svh"
module odp_delay_timer #(
  parameter logic [39:0] DETECT_CYC  = 40'(`ODP_DETECT_CYC),
  parameter logic [39:0] RELEASE_CYC = 40'(`ODP_RELEASE_CYC),
  parameter logic [39:0] WAKE_CYC    = 40'(`ODP_WAKE_CYC)
) (
  input  wire logic  ref_clk_in,
  input  wire logic  reset_n_in,
  odp_timer_if.timer tmr
);
  logic [39:0] count_r;
  logic [39:0] limit;

  function automatic logic [39:0] pick_limit(input logic [1:0] s);
    case (s)
      2'h1:    pick_limit = RELEASE_CYC;
      2'h2:    pick_limit = WAKE_CYC;
      default: pick_limit = DETECT_CYC;
    endcase
  endfunction

  assign limit = pick_limit(tmr.sel);
  assign tmr.done = tmr.start && (count_r >= limit - 40'h1);

  // Restarts whenever the condition drops, so a brief recovery cancels the delay
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || tmr.clear || !tmr.start) begin
      count_r <= 40'h0;
    end else if (!tmr.done) begin
      count_r <= count_r + 40'h1;
    end
  end
endmodule

// ### verilog/odp_cell_compare.sv
/*
  Per-cell comparison of digitised cell voltages against selected thresholds.
  Assumes cell codes arrive as synchronous 8-bit values.
*/
`timescale 1ns/10ps
module odp_cell_compare (
  input  wire logic [31:0] cells_in,
  input  wire logic [31:0] thresh_tbl_in,
  input  wire logic [1:0]  sel_in,
  input  wire logic        above_in,
  output logic             any_out
);
  logic [3:0] hit;
  logic [7:0] th;
  assign th = thresh_tbl_in[sel_in*8 +: 8];
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_cell
      assign hit[i] = above_in ? (cells_in[i*8 +: 8] <= th) : (cells_in[i*8 +: 8] < th);
    end
  endgenerate
  assign any_out = |hit;
endmodule

// ### dv/odp_chk.sv
/* Port checker for overdischarge_sleep_control.
   Assumes the bind after the module reaches the top instance. */
`timescale 1ns/10ps
module odp_chk (
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic       supply_above_return_in,
  input wire logic       config_write_cmd_in,
  input wire logic       control_write_cmd_in,
  input wire logic [7:0] control_data_in,
  input wire logic       discharge_fet_drive_out,
  input wire logic       charge_fet_drive_out,
  input wire logic       regulator_output_out,
  input wire logic       spi_enable_out,
  input wire logic       sleeping_out,
  input wire logic       charge_locked_out,
  input wire logic [7:0] config_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_wake_req; sleeping_out && supply_above_return_in; endsequence
  sequence s_held_high; (!sleeping_out && supply_above_return_in) [*3]; endsequence
  // Write strobe seen while the state was truly sleep
  sequence s_cfg_asleep;
    sleeping_out && config_write_cmd_in ##1 sleeping_out;
  endsequence
  property p_sleep_off; sleeping_out |-> discharge_fet_drive_out && charge_fet_drive_out;
  endproperty
  property p_sleep_power; sleeping_out |-> !regulator_output_out && !spi_enable_out;
  endproperty
  property p_no_sleep; s_held_high |=> !sleeping_out; endproperty
  property p_wake; s_wake_req |-> ##[1:3] !sleeping_out; endproperty
  property p_locked; charge_locked_out |-> discharge_fet_drive_out && charge_fet_drive_out;
  endproperty
  property p_cfg_hold; s_cfg_asleep |=> $stable(config_out);
  endproperty
  // FET turn-on only ever follows a host write two edges earlier
  property p_cfet_cause;
    $fell(charge_fet_drive_out) |->
      $past(control_write_cmd_in, 2) && $past(control_data_in[1], 2);
  endproperty
  property p_dfet_cause;
    $fell(discharge_fet_drive_out) |->
      $past(control_write_cmd_in, 2) && $past(control_data_in[0], 2);
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("FET drive on while asleep");
  a_sleep_power: assert property (p_sleep_power)
    else $error("Regulator or port alive while asleep");
  a_no_sleep: assert property (p_no_sleep)
    else $error("Sleep entered with supply high");
  a_wake: assert property (p_wake)
    else $error("No wake with supply high");
  a_locked: assert property (p_locked)
    else $error("FET drive on while locked");
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("Config changed while asleep");
  a_cfet_cause: assert property (p_cfet_cause)
    else $error("Charge drive fell without a write");
  a_dfet_cause: assert property (p_dfet_cause)
    else $error("Discharge drive fell without a write");
endmodule
bind overdischarge_sleep_control odp_chk i_odp_chk (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .supply_above_return_in(supply_above_return_in),
  .config_write_cmd_in(config_write_cmd_in),
  .control_write_cmd_in(control_write_cmd_in), .control_data_in(control_data_in),
  .discharge_fet_drive_out(discharge_fet_drive_out),
  .charge_fet_drive_out(charge_fet_drive_out),
  .regulator_output_out(regulator_output_out), .spi_enable_out(spi_enable_out),
  .sleeping_out(sleeping_out), .charge_locked_out(charge_locked_out),
  .config_out(config_out)
);

// ### dv/odp_host_model.sv
/* Host stand-in issuing config and control writes.
   Assumes calls come from the bench after reset release. */
`timescale 1ns/10ps
module odp_host_model (
  input  wire logic       ref_clk_in,
  output logic            config_write_cmd_out,
  output logic [7:0]      config_data_out,
  output logic            control_write_cmd_out,
  output logic [7:0]      control_data_out
);
  initial begin
    config_write_cmd_out  = 1'b0;
    config_data_out       = 8'h00;
    control_write_cmd_out = 1'b0;
    control_data_out      = 8'h00;
  end
  // Data flipped after the strobe so stale values never look valid
  task cfg(input logic [7:0] d);
    @(posedge ref_clk_in);
    config_write_cmd_out <= 1'b1;
    config_data_out      <= d;
    @(posedge ref_clk_in);
    config_write_cmd_out <= 1'b0;
    config_data_out      <= ~d;
  endtask
  task ctl(input logic [7:0] d);
    @(posedge ref_clk_in);
    control_write_cmd_out <= 1'b1;
    control_data_out      <= d;
    @(posedge ref_clk_in);
    control_write_cmd_out <= 1'b0;
    control_data_out      <= ~d;
  endtask
endmodule

// ### dv/overdischarge_sleep_control_tb_top.sv
/* Self-checking bench for overdischarge_sleep_control.
   Assumes the host model and bound checker are compiled first. */
`timescale 1ns/10ps
module overdischarge_sleep_control_tb_top;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [31:0] cell_volt  = {4{8'h50}};
  logic        supply_hi  = 1'b0;
  logic        cfg_wr, ctl_wr, dfet_off, cfet_off, reg_on, spi_on, sleep_request_bit, prot, lock;
  logic [7:0]  cfg_d, ctl_d, cfg_q;
  int          n_errors   = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  wire  [7:0]  st = {1'b0, lock, prot, sleep_request_bit, spi_on, reg_on, cfet_off, dfet_off};
  always #2.5 ref_clk_in = ~ref_clk_in;
  odp_host_model i_odp_host_model (.ref_clk_in(ref_clk_in),
    .config_write_cmd_out(cfg_wr), .config_data_out(cfg_d),
    .control_write_cmd_out(ctl_wr), .control_data_out(ctl_d));
  // Short counts keep the run small
  overdischarge_sleep_control #(.DETECT_CYC(40'd20), .RELEASE_CYC(40'd5),
    .WAKE_CYC(40'd30)) i_overdischarge_sleep_control (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cell_volt_in(cell_volt),
    .supply_above_return_in(supply_hi), .config_write_cmd_in(cfg_wr),
    .config_data_in(cfg_d), .control_write_cmd_in(ctl_wr), .control_data_in(ctl_d),
    .discharge_fet_drive_out(dfet_off), .charge_fet_drive_out(cfet_off),
    .regulator_output_out(reg_on), .spi_enable_out(spi_on), .sleeping_out(sleep_request_bit),
    .protect_active_out(prot), .charge_locked_out(lock), .config_out(cfg_q));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task drive(input logic [7:0] c, input logic s);
    @(posedge ref_clk_in);
    cell_volt <= {4{c}};
    supply_hi <= s;
  endtask
  task host_ctl(input logic [7:0] d);
    i_odp_host_model.ctl(d);
    cyc(4);
  endtask
  task host_cfg(input logic [7:0] d);
    i_odp_host_model.cfg(d);
    cyc(4);
  endtask
  task t_start;
    cyc(1);
    chk(st, 8'h0f);
    host_ctl(8'h03);
    chk(st, 8'h0f);
    cyc(35);
    host_cfg(8'h05);
    chk(cfg_q, 8'h05);
    host_ctl(8'h03);
    chk(st, 8'h0c);
    $display("t_start done");
  endtask
  task t_protect;
    drive(8'h2c, 1'b0);
    cyc(10);
    drive(8'h50, 1'b0);
    cyc(30);
    chk(st, 8'h0c);
    drive(8'h2c, 1'b0);
    cyc(30);
    chk(st, 8'h33);
    host_ctl(8'h03);
    host_cfg(8'h15);
    chk(st, 8'h33);
    chk(cfg_q, 8'h05);
    $display("t_protect done");
  endtask
  task t_lock;
    drive(8'h0c, 1'b1);
    cyc(45);
    chk(st & 8'hdf, 8'h4f);
    host_ctl(8'h03);
    chk(st & 8'hdf, 8'h4f);
    host_cfg(8'h15);
    chk(cfg_q, 8'h15);
    drive(8'h0c, 1'b0);
    host_ctl(8'h04);
    cyc(30);
    chk(st & 8'h9f, 8'h13);
    $display("t_lock done");
  endtask
  task t_recover;
    drive(8'h0c, 1'b1);
    cyc(45);
    chk(st & 8'hdf, 8'h0f);
    drive(8'h34, 1'b1);
    host_ctl(8'h03);
    chk(st & 8'hdf, 8'h0d);
    drive(8'h50, 1'b1);
    cyc(10);
    host_ctl(8'h03);
    chk(st & 8'hdf, 8'h0c);
    host_ctl(8'h07);
    chk(st & 8'hdf, 8'h0c);
    drive(8'h50, 1'b0);
    host_ctl(8'h07);
    chk(st & 8'h9f, 8'h13);
    $display("t_recover done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_start();
    t_protect();
    t_lock();
    t_recover();
    report_and_stop();
  end
endmodule
